// [disk_cmd_map.svh]
// register offsets, list word indices, status bits and limits of the disk command engine
`ifndef DISK_CMD_MAP_SVH
`define DISK_CMD_MAP_SVH
`define RG_LIST                   8'h00
`define RG_CTRL                   8'h28
`define RG_STAT                   8'h2c
`define RG_SECB                   8'h30
`define RG_GEOM                   8'h34
`define CTRL_GO                   0
`define SECB_RST                  16'h0100
`define GEOM_RST                  16'h0010
`define GEOM_TWO                  8
`define LW_STAT0                  4'h0
`define LW_STAT1                  4'h1
`define LW_CMD                    4'h2
`define LW_DA0                    4'h3
`define LW_DA1                    4'h4
`define LW_CNT                    4'h5
`define LW_PAGE                   4'h6
`define LW_ADDR                   4'h7
`define LW_RPAGE                  4'h8
`define LW_RADDR                  4'h9
`define LIST_N                    10
`define OP_READ                   8'h03
`define OP_WRITE                  8'h04
`define OP_BOOT                   8'h05
`define UNIT_ERROR_FLAG           15
`define ID_ERROR_FLAG             11
`define DATA_ERROR_FLAG           9
`define DRIVE_OFFLINE_FLAG        0
`define TRACK00_MISS_FLAG         5
`define FIRST_DRIVE_SELECT_JUMPER 2'h0
`define RD_ID_TRY                 3'h5
`define WR_ID_TRY                 3'h4
`define CRC_TRY                   3'h5
`define BOOT_TRY                  3'h6
`define BOOT_SUM_W                10'h01c
`define BOOT_SUM_LAST             10'h026
`define BOOT_LIST_LAST            10'h025
`define ALT1_BYTES                16'h0080
`define ALT2_BYTES                16'h0120
`define ALT1_MAXSEC               5'h18
`define ALT1_LEN                  16'h0c00
`define ALT1_BASE                 16'h00a0
`define ALT1_END                  16'hffff
`define RES_W1_OFS                16'h0002
`define RES_W5_OFS                16'h000a
`define CRC_INIT                  16'hffff
`define CRC_POLY                  16'h1021
`endif

// [dk_pkg.sv]
// types shared by the disk command engine
package dk_pkg;
	typedef enum logic [3:0] {
		ST_IDLE   = 4'h0,
		ST_START  = 4'h1,
		ST_SEEK   = 4'h2,
		ST_FIND   = 4'h3,
		ST_RDREQ  = 4'h4,
		ST_RDW    = 4'h5,
		ST_MWR    = 4'h6,
		ST_WRREQ  = 4'h7,
		ST_MRD    = 4'h8,
		ST_WRW    = 4'h9,
		ST_WCRC   = 4'ha,
		ST_SECEND = 4'hb,
		ST_BDEC   = 4'hc,
		ST_FIN    = 4'hd,
		ST_RES    = 4'he
	} state_t;
	typedef enum logic [1:0] {
		DK_SEEK  = 2'h0,
		DK_FIND  = 2'h1,
		DK_READ  = 2'h2,
		DK_WRITE = 2'h3
	} dk_op_t;
	typedef enum logic [1:0] {
		BT_NONE   = 2'h0,
		BT_PROBE  = 2'h1,
		BT_NATIVE = 2'h2,
		BT_ALT1   = 2'h3
	} boot_t;
endpackage

// [crc_if.sv]
// crc request and result between the command engine and the crc unit
`timescale 1ns/1ps
interface crc_if;
	logic        clear;
	logic        en;
	logic [15:0] data;
	logic [15:0] crc;
	modport engine (output clear, output en, output data, input crc);
	modport unit (input clear, input en, input data, output crc);
endinterface

// [sector_crc.sv]
// per-sector crc accumulator, one 16-bit word a cycle
`timescale 1ns/1ps
`include "disk_cmd_map.svh"
module sector_crc (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// engine side
	crc_if.unit      c
);
	logic [15:0] crc_r;
	logic [15:0] crc_nxt;

	// msb first, same order as the words go to the disk
	function automatic logic [15:0] crc_word(input logic [15:0] crc, input logic [15:0] d);
		logic [15:0] x;
		x = crc;
		for (int i = 15; i >= 0; i--) begin
			x = (x[15] ^ d[i]) ? ((x << 1) ^ `CRC_POLY) : (x << 1);
		end
		return x;
	endfunction

	assign crc_nxt = c.clear ? `CRC_INIT : (c.en ? crc_word(crc_r, c.data) : crc_r);
	assign c.crc   = crc_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crc_r <= `CRC_INIT;
		end else begin
			crc_r <= crc_nxt;
		end
	end
endmodule

// [disk_transfer_boot_commands.sv]
// sector read/write and bootstrap load command engine with apb registers
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "disk_cmd_map.svh"
module disk_transfer_boot_commands #(
	parameter int PAGE_W = 8
) (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// host memory master
	output logic                   mem_req,
	output logic                   mem_we,
	output logic [PAGE_W+15:0]     mem_addr,
	output logic [15:0]            mem_wdata,
	input  wire logic [15:0]       mem_rdata,
	input  wire logic              mem_ack,
	// disk sequencer
	output logic                   dk_req,
	output logic [1:0]             dk_op,
	output logic [1:0]             dk_unit,
	output logic [7:0]             dk_track,
	output logic                   dk_surface,
	output logic [7:0]             dk_sector,
	input  wire logic              dk_ack,
	input  wire logic              dk_hit,
	input  wire logic              dk_rvalid,
	input  wire logic [15:0]       dk_rdata,
	output logic                   dk_rready,
	output logic                   dk_wvalid,
	output logic [15:0]            dk_wdata,
	output logic                   dk_wlast,
	input  wire logic              dk_wready,
	// drive and board pins
	input  wire logic              drive_ready,
	input  wire logic              at_track00,
	input  wire logic              boot_strap
);
	if (PAGE_W < 1 || PAGE_W > 16) begin : g_bad_page
		$error("PAGE_W must be 1..16");
	end

	crc_if crc ();
	sector_crc u_crc (.pclk(pclk), .presetn(presetn), .c(crc));

	dk_pkg::state_t    st_r;
	dk_pkg::boot_t     boot_r;
	logic [15:0]       list_r [`LIST_N];
	logic [15:0]       bl_r [`LIST_N];
	logic [15:0]       secb_r;
	logic [15:0]       geom_r;
	logic [31:0]       rdata_r;
	logic [2:0]        sync1_r;
	logic [2:0]        sync2_r;
	logic [1:0]        pw_r;
	logic [7:0]        op_r;
	logic [1:0]        unit_r;
	logic [7:0]        trk_r;
	logic              surf_r;
	logic [7:0]        sec_r;
	logic [15:0]       cnt_r;
	logic [15:0]       cnt0_r;
	logic [15:0]       scnt_r;
	logic [PAGE_W-1:0] page_r;
	logic [15:0]       offs_r;
	logic [15:0]       soffs_r;
	logic [PAGE_W-1:0] rpage_r;
	logic [15:0]       roffs_r;
	logic [9:0]        idx_r;
	logic [2:0]        try_r;
	logic [2:0]        ctry_r;
	logic [2:0]        btry_r;
	logic [4:0]        altn_r;
	logic [1:0]        ridx_r;
	logic [15:0]       w0_r;
	logic [15:0]       w1_r;
	logic [15:0]       sum_r;
	logic [15:0]       hold_r;
	logic              res_host_r;

	// apb decode
	wire        a_list   = (paddr < `RG_CTRL) && (paddr[1:0] == 2'h0);
	wire [3:0]  a_idx    = paddr[5:2];
	wire        a_ctrl   = paddr == `RG_CTRL;
	wire        a_stat   = paddr == `RG_STAT;
	wire        a_secb   = paddr == `RG_SECB;
	wire        a_geom   = paddr == `RG_GEOM;
	wire        a_hit    = a_list | a_ctrl | a_stat | a_secb | a_geom;
	wire        idle     = st_r == dk_pkg::ST_IDLE;
	wire        apb_wr   = psel & penable & pwrite & a_hit;
	// writes while busy are dropped so a running command sees a stable list
	wire        cfg_we   = apb_wr & idle;
	wire        go       = cfg_we & a_ctrl & pwdata[`CTRL_GO];
	wire        pwr_go   = (pw_r == 2'h2) & sync2_r[2];
	wire [31:0] stat_v   = {26'h0, btry_r, boot_r, ~idle};
	wire [31:0] rd_mux   = a_list ? {16'h0, list_r[a_idx]} :
	                       a_stat ? stat_v :
	                       a_secb ? {16'h0, secb_r} :
	                       a_geom ? {16'h0, geom_r} : 32'h0;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~a_hit;
	assign prdata  = rdata_r;

	// derived engine terms
	wire        rdy_s    = sync2_r[0];
	wire        t0_s     = sync2_r[1];
	wire [9:0]  wps      = secb_r[10:1];
	wire [7:0]  spt      = geom_r[7:0];
	wire [2:0]  try_inc  = try_r + 3'h1;
	wire [2:0]  ctry_inc = ctry_r + 3'h1;
	wire [2:0]  btry_inc = btry_r + 3'h1;
	wire [4:0]  altn_inc = altn_r + 5'h01;
	wire [9:0]  idx_inc  = idx_r + 10'h001;
	wire [15:0] offs_inc = offs_r + 16'h0002;
	wire [15:0] cnt_dec  = (cnt_r < 16'h0002) ? 16'h0000 : cnt_r - 16'h0002;
	wire [15:0] xfer     = cnt0_r - cnt_r;
	wire        is_wr    = op_r == `OP_WRITE;
	wire        op_ok    = (op_r == `OP_READ) | is_wr | (op_r == `OP_BOOT);
	wire [2:0]  id_lim   = is_wr ? `WR_ID_TRY : `RD_ID_TRY;
	wire        retry_bt = (boot_r != dk_pkg::BT_NONE) & w0_r[`UNIT_ERROR_FLAG] &
	                       (btry_inc != `BOOT_TRY);
	wire        fin_list = (st_r == dk_pkg::ST_FIN) & ~retry_bt & ~res_host_r;
	wire        in_sum   = (idx_r >= `BOOT_SUM_W) && (idx_r <= `BOOT_SUM_LAST);
	wire        in_bl    = (idx_r >= `BOOT_SUM_W) && (idx_r <= `BOOT_LIST_LAST);
	wire [3:0]  bl_idx   = 4'(idx_r - `BOOT_SUM_W);
	wire [15:0] res_ofs  = (ridx_r == 2'h0) ? 16'h0000 :
	                       (ridx_r == 2'h1) ? `RES_W1_OFS : `RES_W5_OFS;
	wire [15:0] res_dat  = (ridx_r == 2'h0) ? w0_r : (ridx_r == 2'h1) ? w1_r : xfer;
	wire        crc_word = idx_r == wps;

	// disk sequencer port
	assign dk_req     = (st_r == dk_pkg::ST_SEEK) | (st_r == dk_pkg::ST_FIND) |
	                    (st_r == dk_pkg::ST_RDREQ) | (st_r == dk_pkg::ST_WRREQ);
	assign dk_op      = (st_r == dk_pkg::ST_SEEK)  ? dk_pkg::DK_SEEK :
	                    (st_r == dk_pkg::ST_FIND)  ? dk_pkg::DK_FIND :
	                    (st_r == dk_pkg::ST_WRREQ) ? dk_pkg::DK_WRITE : dk_pkg::DK_READ;
	assign dk_unit    = unit_r;
	assign dk_track   = trk_r;
	assign dk_surface = surf_r;
	assign dk_sector  = sec_r;
	assign dk_rready  = st_r == dk_pkg::ST_RDW;
	assign dk_wvalid  = (st_r == dk_pkg::ST_WRW) | (st_r == dk_pkg::ST_WCRC);
	assign dk_wlast   = st_r == dk_pkg::ST_WCRC;
	assign dk_wdata   = dk_wlast ? crc.crc : hold_r;

	// crc unit
	assign crc.clear  = (st_r == dk_pkg::ST_RDREQ) | (st_r == dk_pkg::ST_WRREQ);
	assign crc.en     = (dk_rready & dk_rvalid & ~crc_word) |
	                    ((st_r == dk_pkg::ST_WRW) & dk_wready);
	assign crc.data   = dk_rready ? dk_rdata : hold_r;

	// host memory port; offset wraps inside the page
	assign mem_req    = (st_r == dk_pkg::ST_MWR) | (st_r == dk_pkg::ST_RES) |
	                    ((st_r == dk_pkg::ST_MRD) & (cnt_r != 16'h0000));
	assign mem_we     = st_r != dk_pkg::ST_MRD;
	assign mem_addr   = (st_r == dk_pkg::ST_RES) ? {rpage_r, 16'(roffs_r + res_ofs)} :
	                    {page_r, offs_r};
	assign mem_wdata  = (st_r == dk_pkg::ST_RES) ? res_dat : hold_r;

	// pins pass two flops before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= 3'h0;
			sync2_r <= 3'h0;
			pw_r    <= 2'h0;
		end else begin
			sync1_r <= {boot_strap, at_track00, drive_ready};
			sync2_r <= sync1_r;
			pw_r    <= (pw_r == 2'h3) ? pw_r : pw_r + 2'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_r <= 32'h0;
			secb_r  <= `SECB_RST;
			geom_r  <= `GEOM_RST;
		end else begin
			if (psel & ~penable) begin
				rdata_r <= rd_mux;
			end
			if (cfg_we & a_secb) begin
				secb_r <= pwdata[15:0];
			end
			if (cfg_we & a_geom) begin
				geom_r <= pwdata[15:0];
			end
		end
	end

	// host command list; results land here unless a disk list ran
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < `LIST_N; i++) begin
				list_r[i] <= 16'h0;
			end
		end else if (cfg_we & a_list) begin
			list_r[a_idx] <= pwdata[15:0];
		end else if (fin_list) begin
			list_r[`LW_STAT0] <= w0_r;
			list_r[`LW_STAT1] <= w1_r;
			list_r[`LW_CNT]   <= xfer;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= dk_pkg::ST_IDLE;
			boot_r <= dk_pkg::BT_NONE;
			for (int i = 0; i < `LIST_N; i++) begin
				bl_r[i] <= 16'h0;
			end
			{op_r, unit_r, trk_r, surf_r, sec_r} <= '0;
			{cnt_r, cnt0_r, scnt_r, offs_r, soffs_r, roffs_r} <= '0;
			{page_r, rpage_r, idx_r, try_r, ctry_r, btry_r, altn_r, ridx_r} <= '0;
			{w0_r, w1_r, sum_r, hold_r, res_host_r} <= '0;
		end else begin
			unique case (st_r)
			dk_pkg::ST_IDLE: begin
				if (go) begin
					op_r   <= list_r[`LW_CMD][7:0];
					unit_r <= list_r[`LW_CMD][15:14];
					trk_r  <= list_r[`LW_DA0][7:0];
					surf_r <= list_r[`LW_DA0][8];
					sec_r  <= list_r[`LW_DA1][7:0];
					cnt_r  <= list_r[`LW_CNT];
					cnt0_r <= list_r[`LW_CNT];
					page_r <= list_r[`LW_PAGE][PAGE_W-1:0];
					offs_r <= list_r[`LW_ADDR];
				end else if (pwr_go) begin
					op_r <= `OP_BOOT;
				end
				if (go | pwr_go) begin
					{w0_r, w1_r, btry_r, res_host_r} <= '0;
					boot_r <= dk_pkg::BT_NONE;
					st_r   <= dk_pkg::ST_START;
				end
			end
			dk_pkg::ST_START: begin
				try_r  <= 3'h0;
				ctry_r <= 3'h0;
				if (op_r == `OP_BOOT && boot_r == dk_pkg::BT_NONE) begin
					boot_r <= dk_pkg::BT_PROBE;
					unit_r <= `FIRST_DRIVE_SELECT_JUMPER;
					{trk_r, surf_r, sec_r, cnt_r, cnt0_r, sum_r} <= '0;
				end else if (!op_ok) begin
					w0_r[`UNIT_ERROR_FLAG] <= 1'b1;
					st_r <= dk_pkg::ST_FIN;
				end else if (!rdy_s) begin
					w1_r[`DRIVE_OFFLINE_FLAG] <= 1'b1;
					w0_r[`UNIT_ERROR_FLAG] <= 1'b1;
					st_r <= dk_pkg::ST_FIN;
				end else begin
					st_r <= dk_pkg::ST_SEEK;
				end
			end
			dk_pkg::ST_SEEK: if (dk_ack) begin
				if (trk_r == 8'h00 && !t0_s) begin
					w1_r[`TRACK00_MISS_FLAG] <= 1'b1;
					w0_r[`UNIT_ERROR_FLAG] <= 1'b1;
					st_r <= dk_pkg::ST_FIN;
				end else begin
					st_r <= dk_pkg::ST_FIND;
				end
			end
			dk_pkg::ST_FIND: if (dk_ack) begin
				if (dk_hit) begin
					st_r <= is_wr ? dk_pkg::ST_WRREQ : dk_pkg::ST_RDREQ;
				end else if (try_inc == id_lim) begin
					w0_r[`ID_ERROR_FLAG]   <= 1'b1;
					w0_r[`UNIT_ERROR_FLAG] <= 1'b1;
					st_r <= dk_pkg::ST_FIN;
				end else begin
					try_r <= try_inc;
				end
			end
			dk_pkg::ST_RDREQ, dk_pkg::ST_WRREQ: if (dk_ack) begin
				idx_r   <= 10'h000;
				scnt_r  <= cnt_r;
				soffs_r <= offs_r;
				st_r    <= is_wr ? dk_pkg::ST_MRD : dk_pkg::ST_RDW;
			end
			dk_pkg::ST_RDW: if (dk_rvalid) begin
				if (crc_word) begin
					if (dk_rdata == crc.crc) begin
						st_r <= dk_pkg::ST_SECEND;
					end else if (ctry_inc == `CRC_TRY) begin
						w0_r[`DATA_ERROR_FLAG] <= 1'b1;
						w0_r[`UNIT_ERROR_FLAG] <= 1'b1;
						st_r <= dk_pkg::ST_FIN;
					end else begin
						// rewind so the retried sector lands on the same host words
						ctry_r <= ctry_inc;
						try_r  <= 3'h0;
						cnt_r  <= scnt_r;
						offs_r <= soffs_r;
						st_r   <= dk_pkg::ST_FIND;
					end
				end else begin
					hold_r <= dk_rdata;
					idx_r  <= idx_inc;
					if (boot_r == dk_pkg::BT_PROBE && in_sum) begin
						sum_r <= sum_r + dk_rdata;
					end
					if (boot_r == dk_pkg::BT_PROBE && in_bl) begin
						bl_r[bl_idx] <= dk_rdata;
					end
					// past the count the sector is still read for its crc
					if (cnt_r != 16'h0000) begin
						st_r <= dk_pkg::ST_MWR;
					end
				end
			end
			dk_pkg::ST_MWR: if (mem_ack) begin
				offs_r <= offs_inc;
				cnt_r  <= cnt_dec;
				st_r   <= dk_pkg::ST_RDW;
			end
			dk_pkg::ST_MRD: begin
				if (cnt_r == 16'h0000) begin
					hold_r <= 16'h0000;
					st_r   <= dk_pkg::ST_WRW;
				end else if (mem_ack) begin
					hold_r <= mem_rdata;
					offs_r <= offs_inc;
					cnt_r  <= cnt_dec;
					st_r   <= dk_pkg::ST_WRW;
				end
			end
			dk_pkg::ST_WRW: if (dk_wready) begin
				idx_r <= idx_inc;
				st_r  <= (idx_inc == wps) ? dk_pkg::ST_WCRC : dk_pkg::ST_MRD;
			end
			dk_pkg::ST_WCRC: if (dk_wready) begin
				st_r <= dk_pkg::ST_SECEND;
			end
			dk_pkg::ST_SECEND: begin
				try_r  <= 3'h0;
				ctry_r <= 3'h0;
				if (boot_r == dk_pkg::BT_PROBE) begin
					st_r <= dk_pkg::ST_BDEC;
				end else if (boot_r == dk_pkg::BT_ALT1 && hold_r == `ALT1_END) begin
					st_r <= dk_pkg::ST_FIN;
				end else if (boot_r == dk_pkg::BT_ALT1 &&
				             (hold_r != 16'(sec_r - 8'h01) || altn_inc == `ALT1_MAXSEC)) begin
					w0_r[`UNIT_ERROR_FLAG] <= 1'b1;
					st_r <= dk_pkg::ST_FIN;
				end else if (boot_r != dk_pkg::BT_ALT1 && cnt_r == 16'h0000) begin
					st_r <= dk_pkg::ST_FIN;
				end else begin
					altn_r <= altn_inc;
					if (sec_r == spt - 8'h01) begin
						sec_r <= 8'h00;
						surf_r <= geom_r[`GEOM_TWO] & ~surf_r;
						if (!geom_r[`GEOM_TWO] || surf_r) begin
							trk_r <= trk_r + 8'h01;
						end
						st_r <= dk_pkg::ST_SEEK;
					end else begin
						sec_r <= sec_r + 8'h01;
						st_r  <= dk_pkg::ST_FIND;
					end
				end
			end
			dk_pkg::ST_BDEC: begin
				if (sum_r == 16'h0000) begin
					// one disk list only: its chain word is never looked at
					boot_r     <= dk_pkg::BT_NATIVE;
					res_host_r <= 1'b1;
					op_r    <= bl_r[`LW_CMD][7:0];
					unit_r  <= bl_r[`LW_CMD][15:14];
					trk_r   <= bl_r[`LW_DA0][7:0];
					surf_r  <= bl_r[`LW_DA0][8];
					sec_r   <= bl_r[`LW_DA1][7:0];
					cnt_r   <= bl_r[`LW_CNT];
					cnt0_r  <= bl_r[`LW_CNT];
					page_r  <= bl_r[`LW_PAGE][PAGE_W-1:0];
					offs_r  <= bl_r[`LW_ADDR];
					rpage_r <= bl_r[`LW_RPAGE][PAGE_W-1:0];
					roffs_r <= bl_r[`LW_RADDR];
					st_r    <= dk_pkg::ST_START;
				end else if (secb_r == `ALT1_BYTES) begin
					boot_r <= dk_pkg::BT_ALT1;
					altn_r <= 5'h00;
					sec_r  <= 8'h01;
					page_r <= '0;
					offs_r <= `ALT1_BASE;
					cnt_r  <= `ALT1_LEN;
					cnt0_r <= `ALT1_LEN;
					st_r   <= dk_pkg::ST_START;
				end else begin
					// second alternate length has no loader here and ends in error
					w0_r[`UNIT_ERROR_FLAG] <= 1'b1;
					st_r <= dk_pkg::ST_FIN;
				end
			end
			dk_pkg::ST_FIN: begin
				// no restore seek and no vector writes on the way out
				if (retry_bt) begin
					btry_r <= btry_inc;
					boot_r <= dk_pkg::BT_NONE;
					op_r   <= `OP_BOOT;
					{w0_r, w1_r, res_host_r} <= '0;
					st_r   <= dk_pkg::ST_START;
				end else begin
					ridx_r <= 2'h0;
					st_r   <= res_host_r ? dk_pkg::ST_RES : dk_pkg::ST_IDLE;
				end
			end
			dk_pkg::ST_RES: if (mem_ack) begin
				ridx_r <= ridx_r + 2'h1;
				if (ridx_r == 2'h2) begin
					st_r <= dk_pkg::ST_IDLE;
				end
			end
			default: st_r <= dk_pkg::ST_IDLE;
			endcase
		end
	end
endmodule

// [disk_transfer_boot_commands_properties.sv]
// port checker for the disk command engine
`timescale 1ns/1ps
module disk_transfer_boot_commands_properties #(
	parameter int PAGE_W = 8
) (
	// clock and reset
	input wire logic               pclk,
	input wire logic               presetn,
	// apb
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pready,
	input wire logic               pslverr,
	// host memory
	input wire logic               mem_req,
	input wire logic               mem_ack,
	input wire logic [PAGE_W+15:0] mem_addr,
	// disk
	input wire logic               dk_req,
	input wire logic               dk_ack,
	input wire logic [1:0]         dk_op,
	input wire logic [7:0]         dk_sector,
	input wire logic               dk_hit,
	input wire logic               dk_wvalid,
	input wire logic               dk_wready,
	input wire logic [15:0]        dk_wdata,
	input wire logic               dk_wlast
);
	logic [2:0] miss_r;
	logic [2:0] miss_nxt;
	// a seek or a hit ends a run of id misses
	assign miss_nxt = (dk_op == dk_pkg::DK_FIND && !dk_hit) ? miss_r + 3'h1 :
		(dk_op == dk_pkg::DK_READ || dk_op == dk_pkg::DK_WRITE) ? miss_r : 3'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			miss_r <= 3'h0;
		end else if (dk_req && dk_ack) begin
			miss_r <= miss_nxt;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_mwait;
		mem_req && !mem_ack;
	endsequence
	property p_rdy; pready; endproperty
	property p_err; pslverr |-> psel && penable; endproperty
	property p_mhold; s_mwait |=> mem_req && $stable(mem_addr); endproperty
	property p_mdrop; mem_req && mem_ack |=> !mem_req; endproperty
	property p_dhold; dk_req && !dk_ack |=> dk_req && $stable(dk_op) && $stable(dk_sector); endproperty
	property p_whold; dk_wvalid && !dk_wready |=> dk_wvalid && $stable({dk_wdata, dk_wlast}); endproperty
	property p_wlast; dk_wvalid && dk_wready && dk_wlast |=> !dk_wvalid; endproperty
	property p_idtry; miss_r <= 3'h5; endproperty
	a_rdy: assert property (p_rdy) else $error("wait state seen");
	a_err: assert property (p_err) else $error("error outside access");
	a_mhold: assert property (p_mhold) else $error("memory request moved");
	a_mdrop: assert property (p_mdrop) else $error("memory request kept");
	a_dhold: assert property (p_dhold) else $error("disk request moved");
	a_whold: assert property (p_whold) else $error("write word moved");
	a_wlast: assert property (p_wlast) else $error("word after crc");
	a_idtry: assert property (p_idtry) else $error("too many id tries");
endmodule
bind disk_transfer_boot_commands disk_transfer_boot_commands_properties
	#(.PAGE_W(PAGE_W)) u_props (.*);

// [disk_host_model.sv]
// host memory and disk drive model
`timescale 1ns/1ps
module disk_host_model (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// host memory
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic [23:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	output logic [15:0]     mem_rdata,
	output logic            mem_ack,
	// disk
	input wire logic        dk_req,
	input wire logic [1:0]  dk_op,
	input wire logic [7:0]  dk_track,
	input wire logic [7:0]  dk_sector,
	output logic            dk_ack,
	output logic            dk_hit,
	output logic            dk_rvalid,
	output logic [15:0]     dk_rdata,
	input wire logic        dk_rready,
	input wire logic        dk_wvalid,
	input wire logic [15:0] dk_wdata,
	output logic            dk_wready,
	// words per sector
	input wire logic [7:0]  wps
);
	logic [15:0] mem [64];
	logic [15:0] wq [$];
	logic [15:0] c, t;
	logic [7:0]  tk, sc, ix, rn, wn, lt;
	logic [23:0] la;
	int          miss, bad, nrd;
	function automatic logic [15:0] crc16(input logic [15:0] a, input logic [15:0] w);
		for (int i = 15; i >= 0; i--)
			a = {a[14:0], 1'b0} ^ ((a[15] ^ w[i]) ? 16'h1021 : 16'h0);
		return a;
	endfunction
	assign dk_rvalid = rn != 8'h0;
	// idle line keeps moving so a stale word is never taken for data
	assign dk_rdata = !dk_rvalid ? t : ix < wps ? {tk, sc} + 16'(ix) : bad > 0 ? ~c : c;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{mem_ack, dk_ack, dk_hit, dk_wready, rn, wn, t, mem_rdata} <= '0;
		end else begin
			t <= t + 16'h1;
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack && $urandom_range(1)) begin
				mem_ack <= 1'b1;
				la <= mem_addr;
				mem_rdata <= mem[mem_addr[6:1]];
				if (mem_we) mem[mem_addr[6:1]] <= mem_wdata;
			end
			dk_ack <= 1'b0;
			dk_hit <= ~dk_hit;
			if (dk_req && !dk_ack && $urandom_range(1)) begin
				dk_ack <= 1'b1;
				dk_hit <= miss == 0;
				if (dk_op == dk_pkg::DK_SEEK) lt <= dk_track;
				if (dk_op == dk_pkg::DK_FIND && miss > 0) miss <= miss - 1;
				if (dk_op == dk_pkg::DK_WRITE) wn <= wps + 8'h1;
				if (dk_op == dk_pkg::DK_READ) begin
					nrd <= nrd + 1;
					{tk, sc} <= {dk_track, dk_sector};
					{rn, ix, c} <= {wps + 8'h1, 8'h0, 16'hffff};
				end
			end
			if (dk_rvalid && dk_rready) begin
				c <= crc16(c, dk_rdata);
				if (ix == wps && bad > 0) bad <= bad - 1;
				{ix, rn} <= {ix + 8'h1, rn - 8'h1};
			end
			dk_wready <= wn != 8'h0 && $urandom_range(1);
			if (dk_wvalid && dk_wready) begin
				wq.push_back(dk_wdata);
				wn <= wn - 8'h1;
			end
		end
	end
endmodule

// [disk_transfer_boot_commands_tb.sv]
// self-checking bench of the disk command engine
`timescale 1ns/1ps
module disk_transfer_boot_commands_tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        mem_req, mem_we, mem_ack, dk_req, dk_ack, dk_hit, dk_rvalid, dk_rready;
	logic        dk_wvalid, dk_wlast, dk_wready, drive_ready, at_track00, boot_strap;
	logic [1:0]  dk_op;
	logic [7:0]  paddr, dk_track, dk_sector, wps;
	logic [15:0] mem_wdata, mem_rdata, dk_rdata, dk_wdata;
	logic [23:0] mem_addr;
	logic [31:0] pwdata, prdata, r;
	logic [32:0] eq [$], mq [$], e, m;
	logic [15:0] w [6];
	int          fail_count, comparisons;
	disk_transfer_boot_commands u_dut (.*, .dk_unit(), .dk_surface());
	disk_host_model u_mod (.*);
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task automatic stop_test();
		// let the monitor take the last read first
		@(posedge pclk);
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic hang();
		fail_count++;
		$display("MISMATCH %0t wait ran out", $time);
		stop_test();
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		comparisons++;
		if (g !== x) begin
			fail_count++;
			$display("MISMATCH %0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
		@(posedge pclk) penable <= 1'b1;
		@(posedge pclk);
		repeat (20) if (pready !== 1'b1) @(posedge pclk);
		if (pready !== 1'b1) hang();
		r = prdata;
		{psel, penable} <= 2'b00;
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] x, input logic [32:0] k);
		@(posedge pclk);
		eq.push_back(x);
		mq.push_back(k);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic cmd(input logic [15:0] c, t, s, n, p, o);
		logic [15:0] v [6];
		v = '{c, t, s, n, p, o};
		foreach (v[i]) apb(1'b1, 8'(8 + 4 * i), {16'h0, v[i]});
		apb(1'b1, 8'h28, 32'h1);
		for (int k = 0; k < 5000; k++) begin
			apb(1'b0, 8'h2c, 32'h0);
			if (r[0] === 1'b0) return;
		end
		hang();
	endtask
	task automatic res(input logic [15:0] a, b, n, input logic [32:0] k);
		rd(8'h00, {17'h0, a}, '1);
		rd(8'h04, {17'h0, b}, '1);
		rd(8'h14, {17'h0, n}, k);
	endtask
	task automatic run(input logic [15:0] c, input int mi, bd, input logic rdy, a0,
		input logic [15:0] tk, a, b);
		{u_mod.miss, u_mod.bad} = {mi, bd};
		{drive_ready, at_track00} <= {rdy, a0};
		// let the pin synchronisers settle
		repeat (4) @(posedge pclk);
		cmd(c, tk, 16'h1, 16'h4, 16'h0, 16'h20);
		res(a, b, (a == 16'h0 || a[9]) ? 16'h4 : 16'h0, '1);
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && eq.size() > 0) begin
			e = eq.pop_front();
			m = mq.pop_front();
			comparisons++;
			if ((({pslverr, prdata} ^ e) & m) !== 33'h0) begin
				fail_count++;
				$display("MISMATCH %0t reg %h got %h", $time, paddr, prdata);
			end
		end
	end
	initial begin
		{presetn, psel, penable, pwrite, boot_strap, paddr, pwdata} = '0;
		{drive_ready, at_track00, wps} = {2'b11, 8'h2};
		void'($urandom(18997));
		foreach (u_mod.mem[i]) u_mod.mem[i] = 16'($urandom);
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h2c, 33'h0, '1);
		rd(8'h30, 33'h100, '1);
		rd(8'h34, 33'h10, '1);
		rd(8'h3c, 33'h100000000, 33'h100000000);
		apb(1'b1, 8'h30, 32'h4);
		apb(1'b1, 8'h34, 32'h2);
		w[0] = u_mod.mem[11];
		w[1] = u_mod.mem[7];
		cmd(16'h3, 16'h1, 16'h1, 16'h6, 16'h0, 16'h10);
		res(16'h0, 16'h0, 16'h6, '1);
		chk({u_mod.mem[8], u_mod.mem[9]}, 32'h01010102);
		chk({u_mod.mem[10], 16'h0}, 32'h02000000);
		chk({u_mod.mem[7], u_mod.mem[11]}, {w[1], w[0]});
		chk({24'h0, u_mod.lt}, 32'h2);
		w = '{u_mod.mem[62], u_mod.mem[63], 16'h0, u_mod.mem[0], 16'h0, 16'h0};
		w[2] = u_mod.crc16(u_mod.crc16(16'hffff, w[0]), w[1]);
		w[5] = u_mod.crc16(u_mod.crc16(16'hffff, w[3]), 16'h0);
		u_mod.wq.delete();
		cmd(16'h4, 16'h1, 16'h1, 16'h6, 16'h3, 16'hfffc);
		res(16'h0, 16'h0, 16'h6, '1);
		chk(u_mod.wq.size(), 6);
		foreach (w[i]) chk({16'h0, u_mod.wq[i]}, {16'h0, w[i]});
		chk({8'h0, u_mod.la}, 32'h30000);
		run(16'h3, 5, 0, 1, 1, 16'h1, 16'h8800, 16'h0);
		run(16'h3, 4, 4, 1, 1, 16'h1, 16'h0, 16'h0);
		run(16'h4, 4, 0, 1, 1, 16'h1, 16'h8800, 16'h0);
		run(16'h3, 0, 5, 1, 1, 16'h1, 16'h8200, 16'h0);
		run(16'h3, 0, 0, 0, 1, 16'h1, 16'h8000, 16'h1);
		run(16'h3, 0, 0, 1, 0, 16'h0, 16'h8000, 16'h20);
		run(16'h7, 0, 0, 1, 1, 16'h1, 16'h8000, 16'h0);
		apb(1'b1, 8'h30, 32'h100);
		wps <= 8'h80;
		u_mod.nrd = 0;
		cmd(16'h5, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
		rd(8'h00, 33'h8000, '1);
		chk(u_mod.nrd, 6);
		stop_test();
	end
endmodule
